// *** core/uart_irq_baud_params.svh ***
// constants for the uart interrupt-enable and baud generator block
// assumes a single 200 MHz ref_clk and a synchronous active-high reset
`ifndef UART_IRQ_BAUD_PARAMS_SVH
`define UART_IRQ_BAUD_PARAMS_SVH

`define ADDR_W 3
// register offsets
`define OFS_DIV_LO 3'h0
`define OFS_DIV_HI 3'h1
`define OFS_INT_EN 3'h2
`define OFS_INT_ID 3'h3
`define OFS_SCRATCH 3'h4
`define OFS_EV_STAT 3'h5
`define OFS_EV_MASK 3'h6

// reset values
`define RST_DIV_LO 8'h0C
`define RST_DIV_HI 8'h00
`define RST_INT_EN 4'h0
`define RST_SCRATCH 8'h00
`define RST_EV_MASK 4'h0
`define RST_SPEED_CFG 2'h0

// field positions of the enable layout
`define BIT_RX_READY 0
`define BIT_TX_EMPTY 1
`define BIT_LINE_ERR 2
`define BIT_HANDSHAKE 3
`define EN_W 4

// ident codes in bits 3:0
`define ID_NONE 4'h1
`define ID_LINE_ERR 4'h6
`define ID_RX_READY 4'h4
`define ID_TX_EMPTY 4'h2
`define ID_HANDSHAKE 4'h0

// clock rates in MHz: 24 MHz tick made from 200 MHz by accumulation
`define CLK_MHZ 200
`define REF_MHZ 24
`define ACC_W 8

// pre-divider as a ratio PREDIV_MOD / step
`define PREDIV_MOD 13
`define PREDIV_STEP_13 5'h01
`define PREDIV_STEP_1625 5'h08
`define PREDIV_STEP_1 5'h0D
`define PREDIV_W 5

`define OVERSAMPLE 16
`define OVS_W 4

`endif

// *** core/uart_irq_baud_pkg.sv ***
// types shared by the uart interrupt-enable and baud generator block
// assumes the params header is compiled alongside
package uart_irq_baud_pkg;

    // pending levels from the rest of the uart
    typedef struct packed {
        logic handshakeChange;
        logic lineError;
        logic txEmpty;
        logic rxReady;
    } irq_src_t;

    // pre-divider choice from the chip config register
    typedef enum logic [1:0] {
        PREDIV_13 = 2'h0,
        PREDIV_1625 = 2'h1,
        PREDIV_1 = 2'h2,
        PREDIV_RSVD = 2'h3
    } prediv_sel_t;

    // timing enables handed to shifters
    typedef struct packed {
        logic sample16;
        logic bitTick;
    } baud_ticks_t;

endpackage

// *** core/baud_divider.sv ***
// 16-bit reloadable divisor counter for the baud generator
// assumes refTick is a one-cycle enable at the reference rate
`timescale 1ns/1ps
`include "uart_irq_baud_params.svh"
module baud_divider #(
    parameter int DIV_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic refTick,
    input wire logic [DIV_W-1:0] divisor,
    // result
    output logic tick16x
);
    logic [DIV_W-1:0] count_reg;
    logic [DIV_W-1:0] count_next;
    logic tick_reg;
    logic tick_next;

    // zero wraps to all ones below, so it divides by 2^DIV_W
    always_comb begin
        count_next = count_reg;
        tick_next = 1'b0;
        if (refTick) begin
            if (count_reg == {DIV_W{1'b0}}) begin
                count_next = divisor - {{(DIV_W-1){1'b0}}, 1'b1};
                tick_next = 1'b1;
            end else begin
                count_next = count_reg - {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_reg <= {DIV_W{1'b0}};
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick16x = tick_reg;
endmodule

// *** core/uart_irq_enable_baud_gen.sv ***
// uart interrupt enable, ident, scratch and baud generator registers
// assumes synchronous inputs, host strobes one cycle long, single clock
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "uart_irq_baud_params.svh"
module uart_irq_enable_baud_gen #(
    parameter int DIV_W = 16,
    parameter int UART_INDEX = 0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    // chip-level configuration
    input wire logic [1:0] chipSpeedConfig,
    input wire uart_irq_baud_pkg::prediv_sel_t chipPredivConfig,
    // pending sources from the uart core
    input wire uart_irq_baud_pkg::irq_src_t irqSrc,
    // interrupt and timing outputs
    output logic irqOut,
    output uart_irq_baud_pkg::baud_ticks_t baudTicks,
    output logic [DIV_W-1:0] divisorOut
);
    import uart_irq_baud_pkg::*;

    // register file
    logic [7:0] divLo_reg;
    logic [7:0] divLo_next;
    logic [7:0] divHi_reg;
    logic [7:0] divHi_next;
    logic [`EN_W-1:0] intEn_reg;
    logic [`EN_W-1:0] intEn_next;
    logic [7:0] scratch_reg;
    logic [7:0] scratch_next;
    logic [`EN_W-1:0] evMask_reg;
    logic [`EN_W-1:0] evMask_next;
    logic [`EN_W-1:0] evStat_reg;
    logic [`EN_W-1:0] evStat_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;

    // interrupt path
    logic [`EN_W-1:0] srcVec;
    logic [`EN_W-1:0] srcPrev_reg;
    logic [`EN_W-1:0] srcPrev_next;
    logic irq_reg;
    logic irq_next;
    logic [`EN_W-1:0] pendLevel;
    logic [`EN_W-1:0] pendSticky;

    // baud path
    logic [`ACC_W-1:0] refAcc_reg;
    logic [`ACC_W-1:0] refAcc_next;
    logic tick24_reg;
    logic tick24_next;
    logic [`PREDIV_W-1:0] preAcc_reg;
    logic [`PREDIV_W-1:0] preAcc_next;
    logic preTick_reg;
    logic preTick_next;
    logic highSpeed;
    logic [`PREDIV_W-1:0] preStep;
    logic tick16;
    logic [`OVS_W-1:0] ovs_reg;
    logic [`OVS_W-1:0] ovs_next;
    logic bitTick_reg;
    logic bitTick_next;
    logic sample_reg;
    logic sample_next;
    logic [DIV_W-1:0] divOut_reg;
    logic [1:0] speedCfg_reg;
    logic [1:0] speedCfg_next;
    prediv_sel_t predivCfg_reg;
    prediv_sel_t predivCfg_next;
    logic cfgChange;

    // ident code of the highest enabled pending source
    function automatic logic [3:0] identCode(
        input logic [`EN_W-1:0] pend
    );
        logic [3:0] code;
        code = `ID_NONE;
        if (pend[`BIT_LINE_ERR]) begin
            code = `ID_LINE_ERR;
        end else if (pend[`BIT_RX_READY]) begin
            code = `ID_RX_READY;
        end else if (pend[`BIT_TX_EMPTY]) begin
            code = `ID_TX_EMPTY;
        end else if (pend[`BIT_HANDSHAKE]) begin
            code = `ID_HANDSHAKE;
        end
        return code;
    endfunction

    function automatic logic hit(
        input logic [`ADDR_W-1:0] a,
        input logic [`ADDR_W-1:0] ofs
    );
        return a == ofs;
    endfunction

    // divisor word as the generator sees it, zero meaning 2^DIV_W
    function automatic logic [DIV_W-1:0] divisorWord(
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        return DIV_W'({hi, lo});
    endfunction

    assign srcVec = {irqSrc.handshakeChange, irqSrc.lineError,
                     irqSrc.txEmpty, irqSrc.rxReady};

    // enabled pending levels, shared by ident and pin
    assign pendLevel = srcVec & intEn_reg;
    assign pendSticky = evStat_reg & evMask_reg & intEn_reg;

    // register writes and reads
    always_comb begin
        divLo_next = divLo_reg;
        divHi_next = divHi_reg;
        intEn_next = intEn_reg;
        scratch_next = scratch_reg;
        evMask_next = evMask_reg;
        rdData_next = 8'h00;
        if (wrStrobe) begin
            if (hit(addr, `OFS_DIV_LO)) begin
                divLo_next = wrData;
            end
            if (hit(addr, `OFS_DIV_HI)) begin
                divHi_next = wrData;
            end
            if (hit(addr, `OFS_INT_EN)) begin
                // upper nibble dropped on purpose
                intEn_next = wrData[`EN_W-1:0];
            end
            if (hit(addr, `OFS_SCRATCH)) begin
                scratch_next = wrData;
            end
            if (hit(addr, `OFS_EV_MASK)) begin
                evMask_next = wrData[`EN_W-1:0];
            end
        end
        if (rdStrobe) begin
            unique case (addr)
                `OFS_DIV_LO: rdData_next = divLo_reg;
                `OFS_DIV_HI: rdData_next = divHi_reg;
                `OFS_INT_EN: rdData_next = {4'h0, intEn_reg};
                `OFS_INT_ID: begin
                    rdData_next = {4'h0, identCode(pendLevel)};
                end
                `OFS_SCRATCH: rdData_next = scratch_reg;
                `OFS_EV_STAT: rdData_next = {4'h0, evStat_reg};
                `OFS_EV_MASK: rdData_next = {4'h0, evMask_reg};
                default: rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            divLo_reg <= `RST_DIV_LO;
            divHi_reg <= `RST_DIV_HI;
            intEn_reg <= `RST_INT_EN;
            scratch_reg <= `RST_SCRATCH;
            evMask_reg <= `RST_EV_MASK;
            rdData_reg <= 8'h00;
        end else begin
            divLo_reg <= divLo_next;
            divHi_reg <= divHi_next;
            intEn_reg <= intEn_next;
            scratch_reg <= scratch_next;
            evMask_reg <= evMask_next;
            rdData_reg <= rdData_next;
        end
    end

    // sticky event bits: rising edge of each source, set beats clear
    always_comb begin
        srcPrev_next = srcVec;
        evStat_next = evStat_reg;
        if (wrStrobe && hit(addr, `OFS_EV_STAT)) begin
            evStat_next = evStat_reg & ~wrData[`EN_W-1:0];
        end
        evStat_next = evStat_next | (srcVec & ~srcPrev_reg);
    end

    // event mask is further gated by the enables so a disabled
    // source can never reach the pin through the sticky path
    always_comb begin
        irq_next = |pendSticky;
        if (pendLevel[`BIT_HANDSHAKE]) begin
            irq_next = 1'b1;
        end
        if (pendLevel[`BIT_LINE_ERR]) begin
            irq_next = 1'b1;
        end
        if (pendLevel[`BIT_TX_EMPTY]) begin
            irq_next = 1'b1;
        end
        if (pendLevel[`BIT_RX_READY]) begin
            irq_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            srcPrev_reg <= {`EN_W{1'b0}};
            evStat_reg <= {`EN_W{1'b0}};
            irq_reg <= 1'b0;
        end else begin
            srcPrev_reg <= srcPrev_next;
            evStat_reg <= evStat_next;
            irq_reg <= irq_next;
        end
    end

    // 24 MHz enable from 200 MHz: 24/200 by accumulation, so the
    // tick spacing jitters by one cycle but the mean rate is exact
    always_comb begin
        tick24_next = 1'b0;
        refAcc_next = refAcc_reg + `ACC_W'(`REF_MHZ);
        if (refAcc_next >= `ACC_W'(`CLK_MHZ)) begin
            refAcc_next = refAcc_next - `ACC_W'(`CLK_MHZ);
            tick24_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            refAcc_reg <= {`ACC_W{1'b0}};
            tick24_reg <= 1'b0;
        end else begin
            refAcc_reg <= refAcc_next;
            tick24_reg <= tick24_next;
        end
    end

    // chip config taken into flops; a change of speed or ratio
    // restarts the pre-divider so no half-old fraction is carried
    always_comb begin
        speedCfg_next = chipSpeedConfig;
        predivCfg_next = chipPredivConfig;
        cfgChange = (speedCfg_next != speedCfg_reg)
                  || (predivCfg_next != predivCfg_reg);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            speedCfg_reg <= `RST_SPEED_CFG;
            predivCfg_reg <= PREDIV_13;
        end else begin
            speedCfg_reg <= speedCfg_next;
            predivCfg_reg <= predivCfg_next;
        end
    end

    // speed bit for this uart: index 0 follows bit 6, 1 follows bit 7
    assign highSpeed = speedCfg_reg[UART_INDEX];

    // pre-divider as fractional ratio mod/step on the 24 MHz tick
    always_comb begin
        if (highSpeed) begin
            preStep = `PREDIV_STEP_1;
        end else begin
            unique case (predivCfg_reg)
                PREDIV_1625: preStep = `PREDIV_STEP_1625;
                PREDIV_1: preStep = `PREDIV_STEP_1;
                default: preStep = `PREDIV_STEP_13;
            endcase
        end
    end

    always_comb begin
        preAcc_next = preAcc_reg;
        preTick_next = 1'b0;
        if (tick24_reg) begin
            preAcc_next = preAcc_reg + preStep;
            if (preAcc_next >= `PREDIV_W'(`PREDIV_MOD)) begin
                preAcc_next = preAcc_next - `PREDIV_W'(`PREDIV_MOD);
                preTick_next = 1'b1;
            end
        end
        if (cfgChange) begin
            preAcc_next = {`PREDIV_W{1'b0}};
            preTick_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            preAcc_reg <= {`PREDIV_W{1'b0}};
            preTick_reg <= 1'b0;
        end else begin
            preAcc_reg <= preAcc_next;
            preTick_reg <= preTick_next;
        end
    end

    baud_divider #(
        .DIV_W(DIV_W)
    ) u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .refTick(preTick_reg),
        .divisor(divisorWord(divHi_reg, divLo_reg)),
        .tick16x(tick16)
    );

    // 16x sample enable and one-per-bit enable for the shifters
    always_comb begin
        sample_next = tick16;
        ovs_next = ovs_reg;
        bitTick_next = 1'b0;
        if (tick16) begin
            ovs_next = ovs_reg + `OVS_W'(1);
            if (ovs_reg == `OVS_W'(`OVERSAMPLE - 1)) begin
                bitTick_next = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ovs_reg <= {`OVS_W{1'b0}};
            bitTick_reg <= 1'b0;
            sample_reg <= 1'b0;
            divOut_reg <= {DIV_W{1'b0}};
        end else begin
            ovs_reg <= ovs_next;
            bitTick_reg <= bitTick_next;
            sample_reg <= sample_next;
            divOut_reg <= divisorWord(divHi_reg, divLo_reg);
        end
    end

    assign rdData = rdData_reg;
    assign irqOut = irq_reg;
    assign baudTicks = '{sample16: sample_reg, bitTick: bitTick_reg};
    assign divisorOut = divOut_reg;
endmodule

// *** tb/uart_irq_enable_baud_gen_properties.sv ***
// port-level assertions for the interrupt-enable and baud block
// assumes one clock domain and one-cycle host strobes
`timescale 1ns/1ps
`include "uart_irq_baud_params.svh"
module uart_irq_enable_baud_gen_checker #(
    parameter int DIV_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [7:0] rdData,
    // configuration and sources
    input wire logic [1:0] chipSpeedConfig,
    input wire uart_irq_baud_pkg::prediv_sel_t chipPredivConfig,
    input wire uart_irq_baud_pkg::irq_src_t irqSrc,
    // outputs
    input wire logic irqOut,
    input wire uart_irq_baud_pkg::baud_ticks_t baudTicks,
    input wire logic [DIV_W-1:0] divisorOut
);
    import uart_irq_baud_pkg::*;
    logic [3:0] enShadow_reg;
    logic [3:0] enShadow_next;
    logic [7:0] scrShadow_reg;
    logic [7:0] scrShadow_next;
    logic [4:0] sampleCnt_reg;
    logic [4:0] sampleCnt_next;
    logic seenBit_reg;
    logic seenBit_next;
    always_comb begin
        enShadow_next = enShadow_reg;
        scrShadow_next = scrShadow_reg;
        if (wrStrobe && addr == `OFS_INT_EN) begin
            enShadow_next = wrData[3:0];
        end
        if (wrStrobe && addr == `OFS_SCRATCH) begin
            scrShadow_next = wrData;
        end
        seenBit_next = seenBit_reg | baudTicks.bitTick;
        sampleCnt_next = 5'(sampleCnt_reg + 5'(baudTicks.sample16));
        if (baudTicks.bitTick) begin
            sampleCnt_next = {4'h0, baudTicks.sample16};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enShadow_reg <= 4'h0;
            scrShadow_reg <= 8'h00;
            sampleCnt_reg <= 5'h00;
            seenBit_reg <= 1'b0;
        end else begin
            enShadow_reg <= enShadow_next;
            scrShadow_reg <= scrShadow_next;
            sampleCnt_reg <= sampleCnt_next;
            seenBit_reg <= seenBit_next;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_EN_READ: assert property (
        $past(rdStrobe && addr == `OFS_INT_EN) |->
        rdData == {4'h0, $past(enShadow_reg)})
        else $error("enable readback wrong");
    AST_NO_IRQ: assert property (
        enShadow_reg == 4'h0 && $past(enShadow_reg) == 4'h0 |-> !irqOut)
        else $error("irq while all disabled");
    AST_HS_IRQ: assert property (
        $past(irqSrc.handshakeChange && enShadow_reg[3]) |-> irqOut)
        else $error("handshake irq missing");
    AST_LE_IRQ: assert property (
        $past(irqSrc.lineError && enShadow_reg[2]) |-> irqOut)
        else $error("line error irq missing");
    AST_TX_IRQ: assert property (
        $past(irqSrc.txEmpty && enShadow_reg[1]) |-> irqOut)
        else $error("tx empty irq missing");
    AST_RX_IRQ: assert property (
        $past(irqSrc.rxReady && enShadow_reg[0]) |-> irqOut)
        else $error("rx ready irq missing");
    AST_SCRATCH: assert property (
        $past(rdStrobe && addr == `OFS_SCRATCH) |->
        rdData == $past(scrShadow_reg))
        else $error("scratch readback wrong");
    AST_DIV_LO: assert property (
        wrStrobe && addr == `OFS_DIV_LO |->
        ##2 (divisorOut[7:0] == $past(wrData, 2) || $past(wrStrobe)))
        else $error("divisor low byte not applied");
    AST_BIT_TICK: assert property (
        baudTicks.bitTick && seenBit_reg |-> sampleCnt_reg == 5'h10)
        else $error("bit tick not every 16 samples");
    AST_S16_PULSE: assert property (
        baudTicks.sample16 |=> !baudTicks.sample16)
        else $error("sample pulse longer than a cycle");
    COV_IRQ: cover property (irqOut && enShadow_reg == 4'h4);
    COV_BIT: cover property (baudTicks.bitTick && seenBit_reg);
    COV_SCR: cover property (rdStrobe && addr == `OFS_SCRATCH);
endmodule

bind uart_irq_enable_baud_gen uart_irq_enable_baud_gen_checker #(
    .DIV_W(DIV_W)
) u_checker (.ref_clk, .rst, .addr, .wrData, .wrStrobe, .rdStrobe,
    .rdData, .chipSpeedConfig, .chipPredivConfig, .irqSrc, .irqOut,
    .baudTicks, .divisorOut);

// *** tb/host_bfm.sv ***
// host processor model issuing register writes and reads
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/1ps
`include "uart_irq_baud_params.svh"
module host_bfm (
    // clock
    input wire logic ref_clk,
    // register port
    output logic [`ADDR_W-1:0] addr,
    output logic [7:0] wrData,
    output logic wrStrobe,
    output logic rdStrobe,
    input wire logic [7:0] rdData
);
    initial begin
        addr = '0;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
        // released lines show a changed pattern, not the last value
        addr <= ~a;
        wrData <= ~d;
    endtask
    task automatic rd(input logic [`ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        addr <= ~a;
        @(posedge ref_clk);
        d = rdData;
    endtask
endmodule

// *** tb/uart_irq_enable_baud_gen_tb_top.sv ***
// self-checking bench for the interrupt-enable and baud block
// assumes host_bfm and the bound checker are compiled first
`timescale 1ns/1ps
`include "uart_irq_baud_params.svh"
module uart_irq_enable_baud_gen_tb_top;
    import uart_irq_baud_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [`ADDR_W-1:0] addr;
    logic [7:0] wrData, rdData, d;
    logic wrStrobe, rdStrobe, irqOut;
    logic [1:0] chipSpeedConfig = 2'h0;
    prediv_sel_t chipPredivConfig = PREDIV_13;
    irq_src_t irqSrc = '0;
    baud_ticks_t baudTicks;
    logic [15:0] divisorOut;
    int mismatches = 0;
    int nCompared = 0;
    always #2.5 ref_clk = ~ref_clk;
    host_bfm u_host_bfm (.ref_clk, .addr, .wrData, .wrStrobe, .rdStrobe,
        .rdData);
    uart_irq_enable_baud_gen u_uart_irq_enable_baud_gen (.ref_clk, .rst,
        .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .chipSpeedConfig,
        .chipPredivConfig, .irqSrc, .irqOut, .baudTicks, .divisorOut);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // pulse counts may land one off depending on phase
    task automatic near(input logic [15:0] got, input logic [15:0] exp);
        chk((got + 16'h1 >= exp && got <= exp + 16'h1) ? exp : got, exp);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        u_host_bfm.rd(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    task automatic test_regs;
        rdc(`OFS_DIV_LO, 8'h0C);
        rdc(`OFS_INT_EN, 8'h00);
        rdc(`OFS_INT_ID, 8'h01);
        u_host_bfm.wr(`OFS_INT_EN, 8'hFF);
        rdc(`OFS_INT_EN, 8'h0F);
        u_host_bfm.wr(`OFS_SCRATCH, 8'hA5);
        u_host_bfm.wr(`OFS_INT_ID, 8'h5A);
        rdc(`OFS_SCRATCH, 8'hA5);
        rdc(`OFS_INT_EN, 8'h0F);
        rdc(`OFS_INT_ID, 8'h01);
        // divisor held briefly so no reload picks up the long value
        u_host_bfm.wr(`OFS_DIV_LO, 8'h34);
        u_host_bfm.wr(`OFS_DIV_HI, 8'h12);
        rdc(`OFS_DIV_HI, 8'h12);
        chk(divisorOut, 16'h1234);
        u_host_bfm.wr(`OFS_DIV_HI, 8'h00);
        rdc(`OFS_DIV_LO, 8'h34);
        rdc(3'h7, 8'h00);
        $display("test_regs done");
    endtask
    task automatic test_irq;
        for (int i = 0; i < 4; i++) begin
            u_host_bfm.wr(`OFS_INT_EN, 8'h01 << i);
            irqSrc <= irq_src_t'(~(4'h1 << i));
            repeat (4) @(posedge ref_clk);
            chk(16'(irqOut), 16'h0000);
            irqSrc <= irq_src_t'(4'hF);
            repeat (2) @(posedge ref_clk);
            chk(16'(irqOut), 16'h0001);
            irqSrc <= '0;
            u_host_bfm.wr(`OFS_EV_STAT, 8'h0F);
        end
        u_host_bfm.wr(`OFS_EV_MASK, 8'h04);
        u_host_bfm.wr(`OFS_INT_EN, 8'h0F);
        irqSrc <= irq_src_t'(4'h4);
        rdc(`OFS_INT_ID, 8'h06);
        irqSrc <= '0;
        repeat (4) @(posedge ref_clk);
        chk(16'(irqOut), 16'h0001);
        rdc(`OFS_EV_STAT, 8'h04);
        u_host_bfm.wr(`OFS_EV_STAT, 8'h04);
        repeat (3) @(posedge ref_clk);
        chk(16'(irqOut), 16'h0000);
        u_host_bfm.wr(`OFS_EV_MASK, 8'h00);
        u_host_bfm.wr(`OFS_INT_EN, 8'h00);
        $display("test_irq done");
    endtask
    task automatic test_baud;
        logic [1:0] spd[5] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h3};
        prediv_sel_t pre[5] = '{PREDIV_13, PREDIV_1625, PREDIV_1,
            PREDIV_13, PREDIV_13};
        logic [7:0] dv[5] = '{8'h01, 8'h01, 8'h03, 8'h01, 8'h02};
        logic [15:0] ex[5] = '{16'h0018, 16'h00C0, 16'h0068, 16'h0138,
            16'h009C};
        logic [15:0] n16, nBit;
        for (int i = 0; i < 5; i++) begin
            // fast mode first so a long pending count drains quickly
            chipSpeedConfig <= 2'h3;
            u_host_bfm.wr(`OFS_DIV_LO, dv[i]);
            repeat (500) @(posedge ref_clk);
            chipSpeedConfig <= spd[i];
            chipPredivConfig <= pre[i];
            repeat (150) @(posedge ref_clk);
            n16 = 16'h0000;
            nBit = 16'h0000;
            repeat (2600) begin
                @(posedge ref_clk);
                n16 += 16'(baudTicks.sample16);
                nBit += 16'(baudTicks.bitTick);
            end
            near(n16, ex[i]);
            if (i == 3) near(nBit, 16'h0014);
        end
        $display("test_baud done");
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        test_regs();
        test_irq();
        test_baud();
        stop_test();
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end
endmodule
